// ===== test/host_model.sv
// host model: register strobes toward the status and queue block
module host_model (
   // clock
   input wire logic clk,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
   end
   // strobe lasts one edge; next access waits a further edge
   task wr(input logic [5:0] a, input logic [7:0] dat);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // data is taken one edge after the strobe edge
   task rd(input logic [5:0] a, output logic [7:0] dat);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
      dat = reg_rdata;
   endtask : rd
   task end_cipher();
      wr(6'h08, 8'h00);
   endtask : end_cipher
endmodule : host_model

// ===== test/tb_nfc_modem_status_fifo.sv
// testbench: status register, data queue and modem phase checks
module tb_nfc_modem_status_fifo;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   // event pulses: start, answer, auth, begin, tx done, rx start, rx done
   logic [6:0] ev = 7'h00;
   logic auto_cmd = 1'b0, passive = 1'b0, trx = 1'b0, txwf = 1'b0, rxwf = 1'b0;
   logic rf = 1'b0, hot = 1'b0, fast = 1'b0;
   logic [7:0] txg = 8'h06, rxg = 8'h0A, wb = 8'h00, d;
   logic reg_wr, reg_rd;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic filt, oerr, ovf, nfull, nempty, ciph, targ;
   logic [2:0] ph;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   initial begin
      forever #2.5 clk = ~clk;
   end
   host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   nfc_modem_status_fifo u_dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_start(ev[0]),
      .auto_anticollision_cmd(auto_cmd), .passive_mode(passive), .target_answered(ev[1]),
      .auth_success(ev[2]), .transceive_active(trx), .begin_transmission(ev[3]), .tx_done(ev[4]),
      .rx_start(ev[5]), .rx_done(ev[6]), .tx_wait_for_field(txwf), .rx_wait_for_field(rxwf),
      .tx_guard_time_setting(txg), .rx_guard_time(rxg), .rf_field_pin(rf), .overtemp_pin(hot),
      .bus_fast_mode(fast), .host_filter_fast(filt), .overtemp_error(oerr), .queue_overflow_err(ovf),
      .queue_nearly_full(nfull), .queue_nearly_empty(nempty), .card_cipher_active(ciph),
      .passive_target_selected(targ), .modem_phase(ph));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask : pulse
   // bounded wait for a phase code, cycles counted in n
   task wait_ph(input logic [2:0] p);
      n = 0;
      while (ph !== p && n < 300) begin
         step(1);
         n++;
      end
   endtask : wait_ph
   // pushed bytes follow a known pattern so pops can be predicted
   task fill(input int k);
      for (int i = 0; i < k; i++) begin
         u_host.wr(status_fifo_pkg::ADDR_BYTE, wb ^ 8'hA5);
         wb++;
      end
      step(1);
   endtask : fill
   task end_sim();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      step(1);
      u_host.rd(status_fifo_pkg::ADDR_STATUS, d);
      chk(d, 8'h00);
      u_host.rd(status_fifo_pkg::ADDR_LEVEL, d);
      chk(d, 8'h00);
      u_host.rd(6'h3F, d);
      chk(d, 8'h00);
      // fast filter: forced or following bus speed
      fast <= 1'b1;
      step(2);
      chk({7'h00, filt}, 8'h01);
      fast <= 1'b0;
      step(2);
      chk({7'h00, filt}, 8'h00);
      u_host.wr(status_fifo_pkg::ADDR_STATUS, 8'h40);
      step(1);
      chk({7'h00, filt}, 8'h01);
      u_host.rd(status_fifo_pkg::ADDR_STATUS, d);
      chk(d, 8'h40);
      // over-temperature clear refused while hot
      hot <= 1'b1;
      step(4);
      chk({7'h00, oerr}, 8'h01);
      u_host.wr(status_fifo_pkg::ADDR_STATUS, 8'h80);
      step(1);
      chk({7'h00, oerr}, 8'h01);
      pulse(0);
      step(1);
      chk({7'h00, oerr}, 8'h01);
      hot <= 1'b0;
      step(4);
      chk({7'h00, oerr}, 8'h01);
      u_host.wr(status_fifo_pkg::ADDR_STATUS, 8'h80);
      step(1);
      chk({7'h00, oerr}, 8'h00);
      // target flag only in passive anticollision
      rf <= 1'b1;
      passive <= 1'b1;
      pulse(1);
      step(1);
      chk({7'h00, targ}, 8'h00);
      auto_cmd <= 1'b1;
      pulse(1);
      step(1);
      chk({7'h00, targ}, 8'h01);
      u_host.rd(status_fifo_pkg::ADDR_STATUS, d);
      chk(d, 8'h10);
      rf <= 1'b0;
      step(5);
      chk({7'h00, targ}, 8'h00);
      // cipher set by authentication, ended by software
      pulse(2);
      step(1);
      chk({7'h00, ciph}, 8'h01);
      u_host.end_cipher();
      step(1);
      chk({7'h00, ciph}, 8'h00);
      // modem phase walk with field wait and guard times
      txwf <= 1'b1;
      trx <= 1'b1;
      wait_ph(3'h1);
      chk({5'h00, ph}, 8'h01);
      pulse(3);
      step(20);
      chk({5'h00, ph}, 8'h02);
      rf <= 1'b1;
      wait_ph(3'h3);
      chk({5'h00, ph}, 8'h03);
      pulse(4);
      wait_ph(3'h5);
      chk({5'h00, ph}, 8'h05);
      chk({7'h00, n >= rxg}, 8'h01);
      pulse(5);
      step(1);
      chk({5'h00, ph}, 8'h06);
      pulse(6);
      trx <= 1'b0;
      step(3);
      chk({5'h00, ph}, 8'h00);
      // second walk: no tx field wait, rx held until field, then abort
      rf <= 1'b0;
      txwf <= 1'b0;
      rxwf <= 1'b1;
      trx <= 1'b1;
      wait_ph(3'h1);
      pulse(3);
      wait_ph(3'h3);
      chk({5'h00, ph}, 8'h03);
      chk({7'h00, n >= txg}, 8'h01);
      pulse(4);
      step(20);
      chk({5'h00, ph}, 8'h04);
      rf <= 1'b1;
      wait_ph(3'h5);
      chk({5'h00, ph}, 8'h05);
      trx <= 1'b0;
      step(2);
      chk({5'h00, ph}, 8'h00);
      // queue fill with alert boundaries, watermark 8
      fill(8);
      chk({6'h00, nfull, nempty}, 8'h01);
      fill(1);
      chk({6'h00, nfull, nempty}, 8'h00);
      fill(46);
      chk({6'h00, nfull, nempty}, 8'h00);
      fill(1);
      chk({6'h00, nfull, nempty}, 8'h02);
      fill(8);
      u_host.rd(status_fifo_pkg::ADDR_LEVEL, d);
      chk(d, 8'h40);
      fill(1);
      chk({7'h00, ovf}, 8'h01);
      u_host.rd(status_fifo_pkg::ADDR_LEVEL, d);
      chk(d, 8'h40);
      pulse(0);
      step(1);
      chk({7'h00, ovf}, 8'h00);
      fill(1);
      chk({7'h00, ovf}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         u_host.rd(status_fifo_pkg::ADDR_BYTE, d);
         chk(d, i[7:0] ^ 8'hA5);
      end
      u_host.rd(status_fifo_pkg::ADDR_LEVEL, d);
      chk(d, 8'h3D);
      u_host.wr(status_fifo_pkg::ADDR_LEVEL, 8'h80);
      step(1);
      chk({7'h00, ovf}, 8'h00);
      u_host.rd(status_fifo_pkg::ADDR_LEVEL, d);
      chk(d, 8'h00);
      u_host.rd(status_fifo_pkg::ADDR_BYTE, d);
      u_host.rd(status_fifo_pkg::ADDR_LEVEL, d);
      chk(d, 8'h00);
      // watermark moved to 2, then refill from the purged pointers
      u_host.wr(status_fifo_pkg::ADDR_WATER, 8'h02);
      u_host.rd(status_fifo_pkg::ADDR_WATER, d);
      chk(d, 8'h02);
      chk({6'h00, nfull, nempty}, 8'h01);
      fill(3);
      chk({6'h00, nfull, nempty}, 8'h00);
      u_host.rd(status_fifo_pkg::ADDR_BYTE, d);
      chk(d, 8'h42 ^ 8'hA5);
      end_sim();
   end
endmodule : tb_nfc_modem_status_fifo

// ===== verilog/byte_queue.sv
// module: 64-byte queue storage with fill count
module byte_queue #(
   parameter int DEPTH = status_fifo_pkg::QUEUE_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // queue port
   queue_if.store q
);
   logic [7:0] mem [DEPTH];
   logic [5:0] wr_ptr;
   logic [5:0] rd_ptr;
   logic [6:0] count;
   logic do_push;
   logic do_pop;
   assign do_push = q.push && (count != 7'(DEPTH));
   assign do_pop = q.pop && (count != 7'h00);
   assign q.count = count;
   assign q.pop_data = mem[rd_ptr];
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= q.push_data;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= 6'h00;
         rd_ptr <= 6'h00;
      end else if (q.purge) begin
         wr_ptr <= 6'h00;
         rd_ptr <= 6'h00;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 6'h01;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 6'h01;
         end
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 7'h00;
      end else if (q.purge) begin
         count <= 7'h00;
      end else if (do_push && !do_pop) begin
         count <= count + 7'h01;
      end else if (do_pop && !do_push) begin
         count <= count - 7'h01;
      end
   end
   property p_full_hold;
      @(posedge clk) disable iff (!reset_n) (q.push && !q.pop && !q.purge && count == 7'(DEPTH)) |=> count == 7'(DEPTH);
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("count moved on full push");
   property p_empty_hold;
      @(posedge clk) disable iff (!reset_n) (q.pop && !q.push && !q.purge && count == 7'h00) |=> count == 7'h00;
   endproperty
   a_empty_hold: assert property (p_empty_hold) else $error("count moved on empty pop");
endmodule : byte_queue

// ===== verilog/nfc_modem_status_fifo.sv
// top: modem status register, data queue and fill control
module nfc_modem_status_fifo (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // framing engine events
   input wire logic cmd_start,
   input wire logic auto_anticollision_cmd,
   input wire logic passive_mode,
   input wire logic target_answered,
   input wire logic auth_success,
   input wire logic transceive_active,
   input wire logic begin_transmission,
   input wire logic tx_done,
   input wire logic rx_start,
   input wire logic rx_done,
   input wire logic tx_wait_for_field,
   input wire logic rx_wait_for_field,
   input wire logic [7:0] tx_guard_time_setting,
   input wire logic [7:0] rx_guard_time,
   // analog pins
   input wire logic rf_field_pin,
   input wire logic overtemp_pin,
   input wire logic bus_fast_mode,
   // status outputs
   output logic host_filter_fast,
   output logic overtemp_error,
   output logic queue_overflow_err,
   output logic queue_nearly_full,
   output logic queue_nearly_empty,
   output logic card_cipher_active,
   output logic passive_target_selected,
   output logic [2:0] modem_phase
);
   queue_if q ();
   logic [1:0] rf_sync;
   logic [1:0] temp_sync;
   logic rf_on;
   logic rf_on_d;
   logic hot;
   logic fast_force;
   logic [5:0] queue_watermark;
   logic [7:0] guard_cnt;
   logic wr_status;
   logic wr_byte;
   logic wr_level;
   logic wr_water;
   logic rd_byte;
   status_fifo_pkg::modem_phase_t phase;
   status_fifo_pkg::modem_phase_t next_phase;

   byte_queue #(.DEPTH(status_fifo_pkg::QUEUE_DEPTH)) u_queue (
      .clk(clk),
      .reset_n(reset_n),
      .q(q)
   );

   // pin synchronisers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rf_sync <= 2'h0;
         temp_sync <= 2'h0;
         rf_on_d <= 1'b0;
      end else begin
         rf_sync <= {rf_sync[0], rf_field_pin};
         temp_sync <= {temp_sync[0], overtemp_pin};
         rf_on_d <= rf_sync[1];
      end
   end
   assign rf_on = rf_sync[1];
   // sensor pin high means at or above the limit
   assign hot = temp_sync[1];

   // address decode
   always_comb begin
      wr_status = 1'b0;
      wr_byte = 1'b0;
      wr_level = 1'b0;
      wr_water = 1'b0;
      rd_byte = 1'b0;
      if (reg_addr == status_fifo_pkg::ADDR_STATUS) begin
         wr_status = reg_wr;
      end else if (reg_addr == status_fifo_pkg::ADDR_BYTE) begin
         wr_byte = reg_wr;
         rd_byte = reg_rd;
      end else if (reg_addr == status_fifo_pkg::ADDR_LEVEL) begin
         wr_level = reg_wr;
      end else if (reg_addr == status_fifo_pkg::ADDR_WATER) begin
         wr_water = reg_wr;
      end
   end

   assign q.push = wr_byte;
   assign q.pop = rd_byte;
   assign q.push_data = reg_wdata;
   assign q.purge = wr_level && reg_wdata[status_fifo_pkg::BIT_PURGE];

   // read mux; purge bit always reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == status_fifo_pkg::ADDR_STATUS) begin
            reg_rdata <= {1'b0, fast_force, 1'b0, passive_target_selected, card_cipher_active, modem_phase};
         end else if (reg_addr == status_fifo_pkg::ADDR_BYTE) begin
            reg_rdata <= q.pop_data;
         end else if (reg_addr == status_fifo_pkg::ADDR_LEVEL) begin
            reg_rdata <= {1'b0, q.count};
         end else if (reg_addr == status_fifo_pkg::ADDR_WATER) begin
            reg_rdata <= {2'b00, queue_watermark};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // control bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fast_force <= 1'b0;
         queue_watermark <= status_fifo_pkg::WATER_RESET;
      end else begin
         if (wr_status) begin
            fast_force <= reg_wdata[status_fifo_pkg::BIT_FAST_FORCE];
         end
         if (wr_water) begin
            queue_watermark <= reg_wdata[5:0];
         end
      end
   end
   assign host_filter_fast = fast_force || bus_fast_mode;

   // over-temp latch; a fresh alarm beats the clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overtemp_error <= 1'b0;
      end else if (hot) begin
         overtemp_error <= 1'b1;
      end else if (wr_status && reg_wdata[status_fifo_pkg::BIT_TEMP_CLR]) begin
         overtemp_error <= 1'b0;
      end
   end

   // overflow cleared by command or purge; set wins over command, purge wins over set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         queue_overflow_err <= 1'b0;
      end else if (wr_byte && !q.purge && q.count == 7'(status_fifo_pkg::QUEUE_DEPTH)) begin
         queue_overflow_err <= 1'b1;
      end else if (cmd_start || q.purge) begin
         queue_overflow_err <= 1'b0;
      end
   end

   assign queue_nearly_full = (7'(status_fifo_pkg::QUEUE_DEPTH) - q.count) <= {1'b0, queue_watermark};
   assign queue_nearly_empty = q.count <= {1'b0, queue_watermark};

   // target selected; field loss clears it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         passive_target_selected <= 1'b0;
      end else if (target_answered && auto_anticollision_cmd && passive_mode) begin
         passive_target_selected <= 1'b1;
      end else if (rf_on_d && !rf_on) begin
         passive_target_selected <= 1'b0;
      end
   end

   // cipher set by auth; software clears it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         card_cipher_active <= 1'b0;
      end else if (auth_success) begin
         card_cipher_active <= 1'b1;
      end else if (wr_status && !reg_wdata[status_fifo_pkg::BIT_CIPHER]) begin
         card_cipher_active <= 1'b0;
      end
   end

   // guard timer counts cycles spent in a wait phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         guard_cnt <= status_fifo_pkg::GUARD_RESET;
      end else if (next_phase != phase) begin
         guard_cnt <= status_fifo_pkg::GUARD_RESET;
      end else if (guard_cnt != 8'hFF) begin
         guard_cnt <= guard_cnt + 8'h01;
      end
   end

   always_comb begin
      next_phase = phase;
      case (phase)
         status_fifo_pkg::PH_IDLE: begin
            if (transceive_active) begin
               next_phase = status_fifo_pkg::PH_WAIT_START;
            end
         end
         status_fifo_pkg::PH_WAIT_START: begin
            if (begin_transmission) begin
               next_phase = status_fifo_pkg::PH_TX_WAIT;
            end
         end
         status_fifo_pkg::PH_TX_WAIT: begin
            if (guard_cnt >= tx_guard_time_setting && (rf_on || !tx_wait_for_field)) begin
               next_phase = status_fifo_pkg::PH_SENDING;
            end
         end
         status_fifo_pkg::PH_SENDING: begin
            if (tx_done) begin
               next_phase = status_fifo_pkg::PH_RX_WAIT;
            end
         end
         status_fifo_pkg::PH_RX_WAIT: begin
            if (guard_cnt >= rx_guard_time && (rf_on || !rx_wait_for_field)) begin
               next_phase = status_fifo_pkg::PH_WAIT_DATA;
            end
         end
         status_fifo_pkg::PH_WAIT_DATA: begin
            if (rx_start) begin
               next_phase = status_fifo_pkg::PH_RECEIVING;
            end
         end
         status_fifo_pkg::PH_RECEIVING: begin
            if (rx_done) begin
               next_phase = status_fifo_pkg::PH_IDLE;
            end
         end
         default: begin
            next_phase = status_fifo_pkg::PH_IDLE;
         end
      endcase
      if (!transceive_active) begin
         next_phase = status_fifo_pkg::PH_IDLE;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= status_fifo_pkg::PH_IDLE;
      end else begin
         phase <= next_phase;
      end
   end
   assign modem_phase = phase;

   // assertions
   sequence s_tx_wait_enter;
      phase == status_fifo_pkg::PH_WAIT_START && begin_transmission && transceive_active;
   endsequence
   property p_tx_wait_min;
      @(posedge clk) disable iff (!reset_n)
         (phase == status_fifo_pkg::PH_TX_WAIT && next_phase == status_fifo_pkg::PH_SENDING)
            |-> guard_cnt >= tx_guard_time_setting;
   endproperty
   a_tx_wait_min: assert property (p_tx_wait_min) else $error("tx wait left early");
   property p_tx_field;
      @(posedge clk) disable iff (!reset_n)
         (phase == status_fifo_pkg::PH_TX_WAIT && tx_wait_for_field && !rf_on) |=>
            phase != status_fifo_pkg::PH_SENDING;
   endproperty
   a_tx_field: assert property (p_tx_field) else $error("sent without field");
   property p_rx_wait_min;
      @(posedge clk) disable iff (!reset_n)
         (phase == status_fifo_pkg::PH_RX_WAIT && next_phase == status_fifo_pkg::PH_WAIT_DATA)
            |-> guard_cnt >= rx_guard_time && (rf_on || !rx_wait_for_field);
   endproperty
   a_rx_wait_min: assert property (p_rx_wait_min) else $error("rx wait left early");
   property p_start_seq;
      @(posedge clk) disable iff (!reset_n) s_tx_wait_enter |=> modem_phase == 3'h2;
   endproperty
   a_start_seq: assert property (p_start_seq) else $error("no tx wait after start");
   property p_idle;
      @(posedge clk) disable iff (!reset_n) !transceive_active |=> modem_phase == 3'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("phase not idle");
   property p_target_gate;
      @(posedge clk) disable iff (!reset_n)
         $rose(passive_target_selected) |-> $past(auto_anticollision_cmd) && $past(passive_mode);
   endproperty
   a_target_gate: assert property (p_target_gate) else $error("target set outside anticollision");
   property p_cipher_set;
      @(posedge clk) disable iff (!reset_n) $rose(card_cipher_active) |-> $past(auth_success);
   endproperty
   a_cipher_set: assert property (p_cipher_set) else $error("cipher set without auth");
   property p_temp_clear;
      @(posedge clk) disable iff (!reset_n) $fell(overtemp_error) |-> !$past(hot);
   endproperty
   a_temp_clear: assert property (p_temp_clear) else $error("over-temp cleared while hot");
   property p_purge;
      @(posedge clk) disable iff (!reset_n) q.purge |=> q.count == 7'h00 && !queue_overflow_err;
   endproperty
   a_purge: assert property (p_purge) else $error("purge did not empty queue");
endmodule : nfc_modem_status_fifo

// ===== verilog/queue_if.sv
// interface: queue push/pop/purge between top and storage
interface queue_if;
   logic push;
   logic pop;
   logic purge;
   logic [7:0] push_data;
   logic [7:0] pop_data;
   logic [6:0] count;
   modport ctrl (output push, output pop, output purge, output push_data, input pop_data, input count);
   modport store (input push, input pop, input purge, input push_data, output pop_data, output count);
endinterface : queue_if

// ===== verilog/status_fifo_pkg.sv
// package: register map, field positions and modem phase codes
package status_fifo_pkg;
   localparam logic [5:0] ADDR_STATUS = 6'h08;
   localparam logic [5:0] ADDR_BYTE = 6'h09;
   localparam logic [5:0] ADDR_LEVEL = 6'h0A;
   localparam logic [5:0] ADDR_WATER = 6'h0B;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [5:0] WATER_RESET = 6'h08;
   localparam int BIT_TEMP_CLR = 7;
   localparam int BIT_FAST_FORCE = 6;
   localparam int BIT_TARGET = 4;
   localparam int BIT_CIPHER = 3;
   localparam int BIT_PURGE = 7;
   localparam int QUEUE_DEPTH = 64;
   localparam int TEMP_LIMIT_C = 125;
   localparam logic [7:0] GUARD_RESET = 8'h00;
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_WAIT_START = 3'h1,
      PH_TX_WAIT = 3'h2,
      PH_SENDING = 3'h3,
      PH_RX_WAIT = 3'h4,
      PH_WAIT_DATA = 3'h5,
      PH_RECEIVING = 3'h6
   } modem_phase_t;
endpackage : status_fifo_pkg
